/* cpes_top.sv */
// performance event selector with counter, reached over axi4-lite
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cpes_regs.svh"
module cpes_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic code_walks_done,
  input wire logic [3:0] code_walk_busy_handlers,
  input wire logic code_miss_second_level_hit,
  input wire logic prefix_length_decode_stall,
  input wire logic [2:0] delivered_uops,
  input wire logic backend_stall,
  input wire logic [7:0] port_dispatch,
  input wire logic store_buffer_full_stall,
  input wire logic l2_miss_load_pending,
  input wire logic l3_miss_load_pending,
  input wire logic exec_stall,
  output logic count_active
);
  logic [31:0] select_q;
  logic [47:0] count_q;
  logic aw_held_q;
  logic w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [3:0] value;
  logic [3:0] incr;
  logic [3:0] empty_slots;
  logic [2:0] port_sel;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  cpes_pkg::cpes_src_t src;

  wire logic [7:0] sel_event = select_q[`CPES_F_EVENT_LSB +: 8];
  wire logic [7:0] sel_umask = select_q[`CPES_F_UMASK_LSB +: 8];
  wire logic [7:0] sel_thresh = select_q[`CPES_F_THRESH_LSB +: 8];
  wire logic sel_enable = select_q[`CPES_F_ENABLE];
  wire logic sel_invert = select_q[`CPES_F_INVERT];

  cpes_decode u_decode (
    .event_num(sel_event),
    .unit_mask(sel_umask),
    .src(src),
    .port_sel(port_sel)
  );

  // empty slots only count while the back end is not stalled
  always_comb begin
    if (backend_stall) empty_slots = 4'h0;
    else empty_slots = `CPES_ISSUE_WIDTH - {1'b0, delivered_uops};
  end

  // per-cycle raw value of the selected condition; the L2 and L3 stall events need both terms
  always_comb begin
    case (src)
      cpes_pkg::CPES_SRC_WALK_DONE: value = {3'h0, code_walks_done};
      cpes_pkg::CPES_SRC_WALK_BUSY: value = code_walk_busy_handlers;
      cpes_pkg::CPES_SRC_SLT_HIT: value = {3'h0, code_miss_second_level_hit};
      cpes_pkg::CPES_SRC_PREFIX: value = {3'h0, prefix_length_decode_stall};
      cpes_pkg::CPES_SRC_EMPTY_SLOTS: value = empty_slots;
      cpes_pkg::CPES_SRC_PORT: value = {3'h0, port_dispatch[port_sel]};
      cpes_pkg::CPES_SRC_SB_STALL: value = {3'h0, store_buffer_full_stall};
      cpes_pkg::CPES_SRC_L2_CYC: value = {3'h0, l2_miss_load_pending};
      cpes_pkg::CPES_SRC_L3_CYC: value = {2'h0, l3_miss_load_pending, 1'b0};
      cpes_pkg::CPES_SRC_L2_STALL: value = (l2_miss_load_pending && exec_stall) ? 4'h5 : 4'h0;
      cpes_pkg::CPES_SRC_L3_STALL: value = (l3_miss_load_pending && exec_stall) ? 4'h6 : 4'h0;
      default: value = 4'h0;
    endcase
  end

  cpes_qualify u_qualify (
    .value(value),
    .threshold(sel_thresh),
    .invert(sel_invert),
    .incr(incr)
  );

  // write address and data may come in either order; each is held until both arrive
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid; // both halves held, response slot free
  wire logic [3:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_ok = (wr_addr == `CPES_ADDR_SELECT) || (wr_addr == `CPES_ADDR_COUNT_LO)
               || (wr_addr == `CPES_ADDR_COUNT_HI);

  // address channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (aw_held_q && w_held_q) aw_held_q <= 1'b0;
    end
  end

  // data channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q) w_held_q <= 1'b0;
    end
  end

  // write response once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPES_RESP_OKAY;
    end else if (s_axi_bvalid) begin
      if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end else if (aw_held_q && w_held_q) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `CPES_RESP_OKAY : `CPES_RESP_SLVERR;
    end
  end

  // event selection register, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_q <= `CPES_SEL_RESET;
    end else if (wr_fire && wr_addr == `CPES_ADDR_SELECT) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) select_q[8*b +: 8] <= wr_data[8*b +: 8];
      end
    end
  end

  // counter: software write wins over the increment in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 48'h0;
    end else if (wr_fire && wr_addr == `CPES_ADDR_COUNT_LO) begin
      count_q[31:0] <= wr_data;
    end else if (wr_fire && wr_addr == `CPES_ADDR_COUNT_HI) begin
      count_q[47:32] <= wr_data[15:0];
    end else if (sel_enable && src != cpes_pkg::CPES_SRC_NONE) begin
      count_q <= count_q + {44'h0, incr};
    end
  end

  // shows, one edge later, whether the selection is live
  always_ff @(posedge aclk) begin
    if (!aresetn) count_active <= 1'b0;
    else count_active <= sel_enable && (src != cpes_pkg::CPES_SRC_NONE);
  end

  // read mux
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CPES_ADDR_SELECT: rd_word = select_q;
      `CPES_ADDR_COUNT_LO: rd_word = count_q[31:0];
      `CPES_ADDR_COUNT_HI: rd_word = {16'h0000, count_q[47:32]};
      `CPES_ADDR_STATUS: rd_word = {27'h0, sel_enable && src != cpes_pkg::CPES_SRC_NONE, src};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // read channel: one cycle to accept, answer the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CPES_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 : (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `CPES_RESP_OKAY : `CPES_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks: per-selection increments, counter stillness and bus refusal

  chk_idle_no_count: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sel_enable && !(aw_held_q && w_held_q)) |=> (count_q == $past(count_q)))
    else $error("counter moved while disabled");
  chk_walk_done_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_enable && src == cpes_pkg::CPES_SRC_WALK_DONE && sel_thresh == 8'h00 && !(aw_held_q && w_held_q))
    |=> (count_q == $past(count_q) + {47'h0, $past(code_walks_done)}))
    else $error("walk completion not counted");
  chk_busy_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_enable && src == cpes_pkg::CPES_SRC_WALK_BUSY && sel_thresh == 8'h00 && !(aw_held_q && w_held_q))
    |=> (count_q == $past(count_q) + {44'h0, $past(code_walk_busy_handlers)}))
    else $error("busy handlers not summed");
  chk_slots_four: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_EMPTY_SLOTS && sel_thresh == 8'h04 && !sel_invert
     && delivered_uops == 3'h0 && !backend_stall) |-> (incr == 4'h1))
    else $error("empty cycle missed");
  chk_fe_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_EMPTY_SLOTS && sel_thresh == 8'h01 && sel_invert && backend_stall) |-> (incr == 4'h1))
    else $error("frontend ok cycle missed");
  chk_port_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_PORT && sel_thresh == 8'h00) |-> (incr == {3'h0, |(port_dispatch & sel_umask)}))
    else $error("wrong dispatch port");
  chk_l3_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_L3_CYC && sel_thresh == 8'h02 && !sel_invert) |-> (incr == {3'h0, l3_miss_load_pending}))
    else $error("l3 miss cycle wrong");
  chk_l2_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_L2_STALL && sel_thresh == 8'h05 && !sel_invert)
    |-> (incr == {3'h0, l2_miss_load_pending && exec_stall}))
    else $error("l2 stall wrong");

  // shared antecedents: counting live and no register write landing this cycle
  sequence s_live_raw;
    sel_enable && sel_thresh == 8'h00 && !(aw_held_q && w_held_q);
  endsequence
  sequence s_live_qual;
    sel_enable && !sel_invert && !(aw_held_q && w_held_q);
  endsequence

  // raw per-cycle sums with no threshold
  chk_slt_hit_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_raw ##0 (src == cpes_pkg::CPES_SRC_SLT_HIT))
    |-> (incr == {3'h0, code_miss_second_level_hit}))
    else $error("second level hit not counted");
  chk_prefix_inc: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_raw ##0 (src == cpes_pkg::CPES_SRC_PREFIX))
    |-> (incr == {3'h0, prefix_length_decode_stall}))
    else $error("prefix stall not counted");
  chk_slots_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_raw ##0 (src == cpes_pkg::CPES_SRC_EMPTY_SLOTS))
    |-> (incr == (backend_stall ? 4'h0 : 4'h4 - {1'b0, delivered_uops})))
    else $error("empty slots not summed");
  chk_sb_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_raw ##0 (src == cpes_pkg::CPES_SRC_SB_STALL))
    |-> (incr == {3'h0, store_buffer_full_stall}))
    else $error("store buffer stall not counted");

  // thresholds turn a per-cycle value into one count per qualifying cycle
  chk_l2_cycles: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_qual ##0 (src == cpes_pkg::CPES_SRC_L2_CYC && sel_thresh == 8'h01))
    |-> (incr == {3'h0, l2_miss_load_pending}))
    else $error("l2 miss cycle wrong");
  chk_l3_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_qual ##0 (src == cpes_pkg::CPES_SRC_L3_STALL && sel_thresh == 8'h06))
    |-> (incr == {3'h0, l3_miss_load_pending && exec_stall}))
    else $error("l3 stall wrong");
  chk_nonzero_cyc: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_qual ##0 (src == cpes_pkg::CPES_SRC_WALK_BUSY && sel_thresh == 8'h01))
    |-> (incr == {3'h0, |code_walk_busy_handlers}))
    else $error("busy cycle not counted once");
  chk_thresh_meet: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_live_qual ##0 (src == cpes_pkg::CPES_SRC_WALK_BUSY && sel_thresh == 8'h03))
    |-> (incr == {3'h0, code_walk_busy_handlers >= 4'h3}))
    else $error("threshold compare wrong");
  chk_thresh_invert: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_invert && src == cpes_pkg::CPES_SRC_EMPTY_SLOTS && sel_thresh == 8'h03 && delivered_uops <= 3'h4)
    |-> (incr == {3'h0, backend_stall || delivered_uops >= 3'h2}))
    else $error("inverted threshold wrong");

  // nothing counts for an unknown pair; the live flag follows one edge later
  chk_none_still: assert property (@(posedge aclk) disable iff (!aresetn)
    (src == cpes_pkg::CPES_SRC_NONE && !(aw_held_q && w_held_q)) |=> (count_q == $past(count_q)))
    else $error("counter moved on unknown event");
  chk_active_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (count_active == ($past(sel_enable) && $past(src) != cpes_pkg::CPES_SRC_NONE)))
    else $error("live flag wrong");

  // a waiting response holds off new requests on its own channel
  chk_wr_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while response waits");
  chk_rd_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data waits");
endmodule

/* cpes_regs.svh */
// constants for the performance event selector: offsets, fields, encodings
`ifndef CPES_REGS_SVH
`define CPES_REGS_SVH
`define CPES_ADDR_SELECT 4'h0
`define CPES_ADDR_COUNT_LO 4'h4
`define CPES_ADDR_COUNT_HI 4'h8
`define CPES_ADDR_STATUS 4'hc
`define CPES_SEL_RESET 32'h0000_0000
`define CPES_F_EVENT_LSB 0
`define CPES_F_UMASK_LSB 8
`define CPES_F_ENABLE 22
`define CPES_F_INVERT 23
`define CPES_F_THRESH_LSB 24
`define CPES_EV_CODE_TLB 8'h85
`define CPES_EV_PREFIX 8'h87
`define CPES_EV_ISSUE 8'h9c
`define CPES_EV_DISPATCH 8'ha1
`define CPES_EV_RESOURCE 8'ha2
`define CPES_EV_ACTIVITY 8'ha3
`define CPES_UM_WALK_DONE 8'h0e
`define CPES_UM_WALK_BUSY 8'h10
`define CPES_UM_SLT_HIT 8'h20
`define CPES_UM_ONE 8'h01
`define CPES_UM_SB 8'h08
`define CPES_UM_L2_CYC 8'h01
`define CPES_UM_L3_CYC 8'h02
`define CPES_UM_L2_STALL 8'h05
`define CPES_UM_L3_STALL 8'h06
`define CPES_ISSUE_WIDTH 4'h4
`define CPES_RESP_OKAY 2'b00
`define CPES_RESP_SLVERR 2'b10
`endif

/* cpes_pkg.sv */
// types shared by the performance event selector
package cpes_pkg;
  typedef enum logic [3:0] {
    CPES_SRC_NONE,
    CPES_SRC_WALK_DONE,
    CPES_SRC_WALK_BUSY,
    CPES_SRC_SLT_HIT,
    CPES_SRC_PREFIX,
    CPES_SRC_EMPTY_SLOTS,
    CPES_SRC_PORT,
    CPES_SRC_SB_STALL,
    CPES_SRC_L2_CYC,
    CPES_SRC_L3_CYC,
    CPES_SRC_L2_STALL,
    CPES_SRC_L3_STALL
  } cpes_src_t;
endpackage

/* cpes_decode.sv */
// event number and unit mask decode into one source selection
`timescale 1ns/1ps
`include "cpes_regs.svh"
module cpes_decode (
  input wire logic [7:0] event_num,
  input wire logic [7:0] unit_mask,
  output cpes_pkg::cpes_src_t src,
  output logic [2:0] port_sel
);
  // unknown pairs decode to none so they never count
  always_comb begin
    src = cpes_pkg::CPES_SRC_NONE;
    port_sel = 3'h0;
    case (event_num)
      `CPES_EV_CODE_TLB: begin
        if (unit_mask == `CPES_UM_WALK_DONE) src = cpes_pkg::CPES_SRC_WALK_DONE;
        else if (unit_mask == `CPES_UM_WALK_BUSY) src = cpes_pkg::CPES_SRC_WALK_BUSY;
        else if (unit_mask == `CPES_UM_SLT_HIT) src = cpes_pkg::CPES_SRC_SLT_HIT;
      end
      `CPES_EV_PREFIX: begin
        if (unit_mask == `CPES_UM_ONE) src = cpes_pkg::CPES_SRC_PREFIX;
      end
      `CPES_EV_ISSUE: begin
        if (unit_mask == `CPES_UM_ONE) src = cpes_pkg::CPES_SRC_EMPTY_SLOTS;
      end
      `CPES_EV_DISPATCH: begin
        // only a single set bit names a port
        if (unit_mask != 8'h00 && (unit_mask & (unit_mask - 8'h01)) == 8'h00) begin
          src = cpes_pkg::CPES_SRC_PORT;
          for (int i = 0; i < 8; i++) begin
            if (unit_mask[i]) port_sel = 3'(i);
          end
        end
      end
      `CPES_EV_RESOURCE: begin
        if (unit_mask == `CPES_UM_SB) src = cpes_pkg::CPES_SRC_SB_STALL;
      end
      `CPES_EV_ACTIVITY: begin
        case (unit_mask)
          `CPES_UM_L2_CYC: src = cpes_pkg::CPES_SRC_L2_CYC;
          `CPES_UM_L3_CYC: src = cpes_pkg::CPES_SRC_L3_CYC;
          `CPES_UM_L2_STALL: src = cpes_pkg::CPES_SRC_L2_STALL;
          `CPES_UM_L3_STALL: src = cpes_pkg::CPES_SRC_L3_STALL;
          default: src = cpes_pkg::CPES_SRC_NONE;
        endcase
      end
      default: src = cpes_pkg::CPES_SRC_NONE;
    endcase
  end
endmodule

/* cpes_qualify.sv */
// per-cycle event value to counter increment with threshold and invert
`timescale 1ns/1ps
module cpes_qualify (
  input wire logic [3:0] value,
  input wire logic [7:0] threshold,
  input wire logic invert,
  output logic [3:0] incr
);
  logic meets;
  // zero threshold sums the raw value; otherwise one per qualifying cycle
  always_comb begin
    meets = ({4'h0, value} >= threshold);
    if (threshold == 8'h00) begin
      incr = value;
    end else if (meets != invert) begin
      incr = 4'h1;
    end else begin
      incr = 4'h0;
    end
  end
endmodule

/* cpes_pipe_model.sv */
// pipeline event source model driving the selector inputs
`timescale 1ns/1ps
module cpes_pipe_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic idle_stall,
  output logic walk,
  output logic [3:0] busy,
  output logic slt,
  output logic pfx,
  output logic [2:0] dlv,
  output logic bstall,
  output logic [7:0] port,
  output logic sb,
  output logic l2,
  output logic l3,
  output logic ex
);
  logic [3:0] k_q;
  // pattern step, advances only while traffic runs
  always_ff @(posedge aclk) begin
    if (!aresetn) k_q <= 4'h0;
    else if (go) k_q <= k_q + 4'h1;
  end
  // idle is quiet; idle stall level chosen so idle cycles add nothing
  assign walk = go & k_q[0];
  assign busy = go ? k_q : 4'h0;
  assign slt = go & k_q[1];
  assign pfx = go & k_q[2];
  assign dlv = go ? {1'b0, k_q[1:0]} + {2'h0, k_q[3]} : 3'h0; // never above four
  assign bstall = go ? k_q[2] & k_q[0] : idle_stall;
  assign port = go ? {k_q, ~k_q} : 8'h0;
  assign sb = go & k_q[3];
  assign l2 = go & (k_q[0] ^ k_q[1]);
  assign l3 = go & k_q[1];
  assign ex = go & k_q[2];
endmodule

/* core_perf_event_select_bench.sv */
// self-checking bench for the performance event selector
`timescale 1ns/1ps
`include "cpes_regs.svh"
module core_perf_event_select_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic go = 1'b0, idle_stall = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, act, walk, slt, pfx, bstall, sb, l2, l3, ex;
  logic [1:0] bresp, rresp, wr_resp;
  logic [31:0] rdata, sel_q;
  logic [3:0] busy;
  logic [2:0] dlv;
  logic [7:0] port;
  logic [47:0] exp_q;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  always #2 aclk = ~aclk;
  cpes_top cpes_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .code_walks_done(walk),
    .code_walk_busy_handlers(busy), .code_miss_second_level_hit(slt), .prefix_length_decode_stall(pfx),
    .delivered_uops(dlv), .backend_stall(bstall), .port_dispatch(port), .store_buffer_full_stall(sb),
    .l2_miss_load_pending(l2), .l3_miss_load_pending(l3), .exec_stall(ex), .count_active(act));
  cpes_pipe_model cpes_pipe_model_inst (.aclk(aclk), .aresetn(aresetn), .go(go), .idle_stall(idle_stall),
    .walk(walk), .busy(busy), .slt(slt), .pfx(pfx), .dlv(dlv), .bstall(bstall), .port(port), .sb(sb),
    .l2(l2), .l3(l3), .ex(ex));
  // per-cycle value of a selection, top bit set when the encoding exists
  function automatic logic [4:0] raw_of(input logic [15:0] eu);
    case (eu)
      16'h0e85: raw_of = {4'h8, walk};
      16'h1085: raw_of = {1'b1, busy};
      16'h2085: raw_of = {4'h8, slt};
      16'h0187: raw_of = {4'h8, pfx};
      16'h019c: raw_of = bstall ? 5'h10 : 5'h14 - {2'h0, dlv};
      16'h08a2: raw_of = {4'h8, sb};
      16'h01a3: raw_of = {4'h8, l2};
      16'h02a3: raw_of = l3 ? 5'h12 : 5'h10;
      16'h05a3: raw_of = (l2 & ex) ? 5'h15 : 5'h10;
      16'h06a3: raw_of = (l3 & ex) ? 5'h16 : 5'h10;
      default: raw_of = (eu[7:0] == 8'ha1 && $onehot(eu[15:8])) ? {4'h8, |(port & eu[15:8])} : 5'h0;
    endcase
  endfunction
  function automatic logic [3:0] inc_of(input logic [31:0] s);
    logic [4:0] r;
    r = raw_of(s[15:0]);
    if (!(r[4] && s[22])) inc_of = 4'h0;
    else if (s[31:24] == 8'h0) inc_of = r[3:0];
    else inc_of = {3'h0, s[23] ? ({4'h0, r[3:0]} < s[31:24]) : ({4'h0, r[3:0]} >= s[31:24])};
  endfunction
  function automatic logic [31:0] mk(input logic [7:0] ev, um, th, input int threshold_invert, en);
    mk = {th, threshold_invert[0], en[0], 6'h0, um, ev};
  endfunction
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    wr_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // program, preset the count, run traffic, then read back both words
  task automatic run_ev(input logic [31:0] s, input logic [31:0] lo0);
    logic [31:0] lo, hi;
    logic [1:0] r;
    idle_stall <= !s[23];
    sel_q = s;
    axw(4'h0, s);
    axw(4'h4, lo0);
    axw(4'h8, 32'h0);
    exp_q = {16'h0, lo0};
    go <= 1'b1;
    // reference sum follows the inputs the counter sees while traffic runs
    repeat (40) begin
      @(posedge aclk);
      exp_q = exp_q + {44'h0, inc_of(sel_q)};
    end
    go <= 1'b0;
    repeat (3) @(posedge aclk);
    axr(4'h4, lo, r);
    axr(4'h8, hi, r);
    chk(lo, exp_q[31:0]);
    chk(hi, {16'h0, exp_q[47:32]});
  endtask
  task automatic t_fetch();
    run_ev(mk(8'h85, 8'h0e, 8'h0, 0, 1), 32'h0);
    run_ev(mk(8'h85, 8'h10, 8'h0, 0, 1), 32'hffff_fff0);
    run_ev(mk(8'h85, 8'h20, 8'h0, 0, 1), 32'h0);
    run_ev(mk(8'h87, 8'h01, 8'h0, 0, 1), 32'h0);
    $display("done fetch");
  endtask
  task automatic t_issue();
    run_ev(mk(8'h9c, 8'h01, 8'h0, 0, 1), 32'h0);
    run_ev(mk(8'h9c, 8'h01, 8'h4, 0, 1), 32'h0);
    for (int n = 1; n < 4; n++) run_ev(mk(8'h9c, 8'h01, 8'(4 - n), 0, 1), 32'h0);
    run_ev(mk(8'h9c, 8'h01, 8'h1, 1, 1), 32'h0);
    $display("done issue");
  endtask
  task automatic t_ports();
    for (int i = 0; i < 8; i++) run_ev(mk(8'ha1, 8'h01 << i, 8'h0, 0, 1), 32'h0);
    $display("done ports");
  endtask
  task automatic t_stalls();
    run_ev(mk(8'ha2, 8'h08, 8'h0, 0, 1), 32'h0);
    run_ev(mk(8'ha3, 8'h01, 8'h1, 0, 1), 32'h0);
    run_ev(mk(8'ha3, 8'h02, 8'h2, 0, 1), 32'h0);
    run_ev(mk(8'ha3, 8'h05, 8'h5, 0, 1), 32'h0);
    run_ev(mk(8'ha3, 8'h06, 8'h6, 0, 1), 32'h0);
    $display("done stalls");
  endtask
  task automatic t_thresh();
    run_ev(mk(8'h85, 8'h10, 8'h1, 0, 1), 32'h0);
    run_ev(mk(8'h85, 8'h10, 8'h3, 0, 1), 32'h0);
    run_ev(mk(8'h9c, 8'h01, 8'h3, 1, 1), 32'h0);
    $display("done thresh");
  endtask
  // unimplemented codes and a disabled counter must stay still
  task automatic t_impl();
    logic [31:0] d;
    logic [1:0] r;
    run_ev(mk(8'h85, 8'h0e, 8'h0, 0, 1), 32'h0);
    axr(4'hc, d, r);
    chk(d, {27'h0, 1'b1, cpes_pkg::CPES_SRC_WALK_DONE});
    chk({31'h0, act}, 32'h1);
    run_ev(mk(8'ha3, 8'h04, 8'h4, 0, 1), 32'h5);
    run_ev(mk(8'ha1, 8'h03, 8'h0, 0, 1), 32'h0);
    run_ev(mk(8'h85, 8'h0e, 8'h0, 0, 0), 32'h0);
    axr(4'hc, d, r);
    chk(d & 32'h10, 32'h0);
    chk({31'h0, act}, 32'h0);
    $display("done impl");
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axr(4'h0, d, r);
    chk(d, `CPES_SEL_RESET);
    axr(4'h4, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `CPES_RESP_OKAY});
    axr(4'h2, d, r);
    chk({30'h0, r}, {30'h0, `CPES_RESP_SLVERR});
    chk(d, 32'h0);
    axw(4'h4, 32'hdead_beef);
    chk({30'h0, wr_resp}, {30'h0, `CPES_RESP_OKAY});
    axw(4'h8, 32'h0000_abcd);
    axw(4'hc, 32'h0000_0001);
    chk({30'h0, wr_resp}, {30'h0, `CPES_RESP_SLVERR});
    axr(4'h4, d, r);
    chk(d, 32'hdead_beef);
    axr(4'h8, d, r);
    chk(d, 32'h0000_abcd);
    $display("done regs");
  endtask
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_fetch();
    t_issue();
    t_ports();
    t_stalls();
    t_thresh();
    t_impl();
    finish_test();
  end
endmodule
